// ### core/mcb_core.sv
// Purpose: core control: work regs, return stack, power-down,
//          external interrupt pin and shared port pins
// Assumes: classic Wishbone slave, software is the only party
// Notes:   commands are one-shot writes to the command register
// Function
// - after reset selector, pointer, temp undefined
// - after back-up return work registers undefined
// - eight-entry return stack with index
// - interrupts and table references consume entries
// - serial use keeps port 0 bits usable
// - timer pins keep port 1 bits readable
// - interrupt and analog pins keep port use
// - back-up only after arm then power-down
// - pin control bit 3 gates interrupt pin
// - changing bit 3 may set request flag
// - skip-and-clear command clears request flag while enable bit 0 is zero
// - bit 3 zero disables interrupt pin
`timescale 1ns/1ps
module mcb_core
  import mcb_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // wishbone slave
  input  wire mcb_wb_req_t       i_wb,
  output logic                   o_wb_ack,
  output logic        [31:0]     o_wb_dat,
  // port pins
  input  wire logic   [PORT_W-1:0] i_port_pin,
  output logic        [PORT_W-1:0] o_port_pin,
  output logic        [PORT_W-1:0] o_port_oe,
  // function pins with own thresholds
  input  wire logic   [FN_W-1:0] i_fn_pin,
  input  wire logic              i_wake_pin,
  output logic        [FN_W-1:0] o_fn_in,
  // peripheral drive
  input  wire logic              i_serial_out,
  input  wire logic   [1:0]      i_timer_out,
  // core status
  output logic                   o_ext_irq_req,
  output logic                   o_skip,
  output logic                   o_backup,
  output logic                   o_irq
);

  // ***************************************************
  // declarations
  // ***************************************************
  logic [PORT_W-1:0] port_in;
  logic              wake_lvl;
  logic              ack_q;
  logic [31:0]       rd_data;
  logic              wr_fire;
  logic [31:0]       wmask;
  logic [CMD_W-1:0]  cmd;
  logic              cmd_ok;
  logic              pdown_only;
  logic [3:0]        pin_ctrl_q;
  logic [3:0]        irq_en_q;
  logic              keyon_q;
  logic              ie_q;
  logic [2:0]        func_q;
  logic [PORT_W-1:0] port_out_q;
  logic [PORT_W-1:0] port_oe_q;
  logic [PC_W-1:0]   stk_data_q;
  mcb_work_t         work_q;
  logic [INT_W-1:0]  int_stat_q;
  logic [INT_W-1:0]  int_mask_q;
  logic [INT_W-1:0]  int_set;
  mcb_pstate_t       ps_q;
  logic              gated_int;
  logic              gated_prev_q;
  logic              ext_edge;
  logic              ext_flag_q;
  logic              snz;
  logic              skip_q;
  logic              wake;
  logic              stk_push;
  logic              stk_pop;
  logic [PC_W-1:0]   stk_top;
  logic [SP_W-1:0]   stk_index;
  logic              stk_ovf;
  logic [PORT_W-1:0] pin_out_d;
  logic [PORT_W-1:0] pin_oe_d;

  // ***************************************************
  // pin synchronisers and return stack
  // ***************************************************
  mcb_sync #(.W(PORT_W + FN_W + 1)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_wake_pin, i_fn_pin, i_port_pin}),
    .o_sync    ({wake_lvl, o_fn_in, port_in})
  );

  mcb_ret_stack u_stack (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_push    (stk_push),
    .i_pop     (stk_pop),
    .i_data    (stk_data_q),
    .o_top     (stk_top),
    .o_index   (stk_index),
    .o_ovf     (stk_ovf)
  );

  // ***************************************************
  // bus slave
  // ***************************************************
  // write lands at the edge where the master sees ack
  assign wr_fire  = i_wb.cyc && i_wb.stb && i_wb.we && ack_q;
  assign o_wb_ack = ack_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{i_wb.sel[i]}};
    end
  end

  assign cmd = (wr_fire && i_wb.adr == OFS_CMD)
             ? CMD_W'(i_wb.dat & wmask) : '0;
  // the core sleeps in back-up, so commands are dropped there
  assign cmd_ok     = (|cmd) && (ps_q != PS_BACKUP);
  assign pdown_only = cmd_ok && (cmd == CMD_W'(1 << CMD_PDOWN));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q    <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack_q <= i_wb.cyc && i_wb.stb && !ack_q;
      if (i_wb.cyc && i_wb.stb && !ack_q) begin
        o_wb_dat <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (i_wb.adr)
      OFS_PIN_CTRL: rd_data[3:0] = pin_ctrl_q;
      OFS_IRQ_EN:   rd_data[3:0] = irq_en_q;
      OFS_KEYON:    rd_data[0] = keyon_q;
      OFS_STK_DATA: rd_data[PC_W-1:0] = stk_top;
      OFS_STATUS: begin
        rd_data[ST_FLAG]            = ext_flag_q;
        rd_data[ST_SKIP]            = skip_q;
        rd_data[ST_PS +: 2]         = ps_q;
        rd_data[ST_SP +: SP_W]      = stk_index;
        rd_data[ST_IE]              = ie_q;
      end
      OFS_WORK:     rd_data[WORK_W-1:0] = work_q;
      OFS_INT_STAT: rd_data[INT_W-1:0] = int_stat_q;
      OFS_INT_MASK: rd_data[INT_W-1:0] = int_mask_q;
      OFS_PORT_OUT: rd_data[PORT_W-1:0] = port_out_q;
      OFS_PORT_OE:  rd_data[PORT_W-1:0] = port_oe_q;
      // pin levels stay readable under every shared function
      OFS_PORT_IN:  rd_data[PORT_W-1:0] = port_in;
      OFS_FUNC:     rd_data[2:0] = func_q;
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  // ***************************************************
  // software-written control registers
  // ***************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_ctrl_q <= RST_PIN_CTRL;
      irq_en_q   <= RST_IRQ_EN;
      keyon_q    <= 1'b0;
      func_q     <= RST_FUNC;
      port_out_q <= RST_PORT;
      port_oe_q  <= RST_PORT;
      int_mask_q <= RST_INT_MASK;
      stk_data_q <= '0;
    end else if (wr_fire) begin
      case (i_wb.adr)
        OFS_PIN_CTRL: pin_ctrl_q <= 4'((pin_ctrl_q & ~wmask[3:0])
                                   | (i_wb.dat[3:0] & wmask[3:0]));
        OFS_IRQ_EN:   irq_en_q <= 4'((irq_en_q & ~wmask[3:0])
                                 | (i_wb.dat[3:0] & wmask[3:0]));
        OFS_KEYON:    keyon_q <= i_wb.sel[0] ? i_wb.dat[0] : keyon_q;
        OFS_FUNC:     func_q <= i_wb.sel[0] ? i_wb.dat[2:0] : func_q;
        OFS_PORT_OUT: port_out_q <= (port_out_q & ~wmask[PORT_W-1:0])
                                  | (i_wb.dat[PORT_W-1:0]
                                     & wmask[PORT_W-1:0]);
        OFS_PORT_OE:  port_oe_q <= (port_oe_q & ~wmask[PORT_W-1:0])
                                 | (i_wb.dat[PORT_W-1:0]
                                    & wmask[PORT_W-1:0]);
        OFS_INT_MASK: int_mask_q <= i_wb.sel[0] ? i_wb.dat[INT_W-1:0]
                                               : int_mask_q;
        OFS_STK_DATA: stk_data_q <= (stk_data_q & ~wmask[PC_W-1:0])
                                  | (i_wb.dat[PC_W-1:0]
                                     & wmask[PC_W-1:0]);
        default: ;
      endcase
    end
  end

  // global interrupt enable, cleared by the disable command
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ie_q <= 1'b0;
    end else if (cmd_ok && cmd[CMD_DI]) begin
      ie_q <= 1'b0;
    end else if (cmd_ok && cmd[CMD_EI]) begin
      ie_q <= 1'b1;
    end
  end

  // ***************************************************
  // work registers
  // ***************************************************
  // no reset on purpose: selector, pointer and temp start unknown
  always_ff @(posedge i_ref_clk) begin
    if (wake) begin
      work_q <= mcb_work_t'(WORK_JUNK);
    end else if (wr_fire && i_wb.adr == OFS_WORK) begin
      work_q <= mcb_work_t'((work_q & ~wmask[WORK_W-1:0])
                | (i_wb.dat[WORK_W-1:0] & wmask[WORK_W-1:0]));
    end
  end

  // ***************************************************
  // return stack requests
  // ***************************************************
  // one entry per write, whichever pushing command is given
  assign stk_push = cmd_ok && (cmd[CMD_CALL] || cmd[CMD_IRQ_ENT]
                    || cmd[CMD_TBL_REF]);
  assign stk_pop  = cmd_ok && cmd[CMD_RET];

  // ***************************************************
  // external interrupt pin and request flag
  // ***************************************************
  // gating ahead of the edge detector makes a bit 3 change an edge
  assign gated_int = o_fn_in[PIN_INT] && pin_ctrl_q[PIN_EN_BIT];
  assign ext_edge  = pin_ctrl_q[PIN_EDGE_BIT]
                   ? (gated_int && !gated_prev_q)
                   : (!gated_int && gated_prev_q);
  assign snz = cmd_ok && cmd[CMD_SKIP_CLR] && !irq_en_q[EN_EXT_BIT];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gated_prev_q <= 1'b0;
      ext_flag_q   <= 1'b0;
      skip_q       <= 1'b0;
      o_skip       <= 1'b0;
    end else begin
      gated_prev_q <= gated_int;
      if (ext_edge) begin
        ext_flag_q <= 1'b1;
      end else if ((snz && ext_flag_q)
                   || (cmd_ok && cmd[CMD_IRQ_ENT])) begin
        ext_flag_q <= 1'b0;
      end
      o_skip <= snz && ext_flag_q;
      if (snz) begin
        skip_q <= ext_flag_q;
      end
    end
  end

  // ***************************************************
  // power-down sequencing
  // ***************************************************
  assign wake = (ps_q == PS_BACKUP)
              && (wake_lvl || (keyon_q && ext_edge));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ps_q <= PS_RUN;
    end else begin
      case (ps_q)
        PS_RUN: begin
          if (cmd_ok && cmd[CMD_ARM] && !cmd[CMD_PDOWN]) begin
            ps_q <= PS_ARMED;
          end
        end
        PS_ARMED: begin
          if (pdown_only) begin
            ps_q <= PS_BACKUP;
          end else if (cmd_ok && !cmd[CMD_ARM]) begin
            ps_q <= PS_RUN;
          end
        end
        PS_BACKUP: begin
          if (wake) begin
            ps_q <= PS_RUN;
          end
        end
        default: ps_q <= PS_RUN;
      endcase
    end
  end

  // ***************************************************
  // interrupt status and outputs
  // ***************************************************
  always_comb begin
    int_set           = '0;
    int_set[INT_EXT]  = ext_edge;
    int_set[INT_WAKE] = wake;
    int_set[INT_OVF]  = stk_ovf;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      int_stat_q    <= '0;
      o_irq         <= 1'b0;
      o_ext_irq_req <= 1'b0;
      o_backup      <= 1'b0;
    end else begin
      // a new event beats a clear in the same cycle
      if (wr_fire && i_wb.adr == OFS_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~INT_W'(i_wb.dat & wmask))
                    | int_set;
      end else begin
        int_stat_q <= int_stat_q | int_set;
      end
      o_irq         <= |(int_stat_q & int_mask_q);
      o_ext_irq_req <= ext_flag_q && irq_en_q[EN_EXT_BIT] && ie_q;
      o_backup      <= (ps_q == PS_BACKUP);
    end
  end

  // ***************************************************
  // shared port pins
  // ***************************************************
  // peripherals only take over drive; inputs are never blocked
  always_comb begin
    pin_out_d = port_out_q;
    pin_oe_d  = port_oe_q;
    if (func_q[FN_SERIAL]) begin
      pin_out_d[P0_SERIAL_OUT_PIN] = i_serial_out;
      pin_oe_d[P0_SERIAL_OUT_PIN]  = 1'b1;
    end
    if (func_q[FN_TMRA_OUT]) begin
      pin_out_d[P1_TMRA] = i_timer_out[0];
      pin_oe_d[P1_TMRA]  = 1'b1;
    end
    if (func_q[FN_TMRB_OUT]) begin
      pin_out_d[P1_TMRB] = i_timer_out[1];
      pin_oe_d[P1_TMRB]  = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_pin <= RST_PORT;
      o_port_oe  <= RST_PORT;
    end else begin
      o_port_pin <= pin_out_d;
      o_port_oe  <= pin_oe_d;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  property p_edge_sets_flag;
    @(posedge i_ref_clk) disable iff (i_rst)
      ext_edge |=> ext_flag_q && int_stat_q[INT_EXT];
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag)
    else $error("pin edge lost");

  property p_disabled_quiet;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!pin_ctrl_q[PIN_EN_BIT] && !gated_prev_q) |-> !ext_edge;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled pin raised an edge");

  property p_gate;
    @(posedge i_ref_clk) disable iff (i_rst)
      !pin_ctrl_q[PIN_EN_BIT] |-> !gated_int;
  endproperty
  a_gate: assert property (p_gate)
    else $error("pin passed while gated off");

  property p_skip_clears;
    @(posedge i_ref_clk) disable iff (i_rst)
      (snz && ext_flag_q && !ext_edge) |=> !ext_flag_q && o_skip
        && skip_q ##1 !o_skip;
  endproperty
  a_skip_clears: assert property (p_skip_clears)
    else $error("skip-and-clear misbehaved");

  property p_snz_blocked;
    @(posedge i_ref_clk) disable iff (i_rst)
      (cmd_ok && cmd[CMD_SKIP_CLR] && irq_en_q[EN_EXT_BIT])
        |=> !o_skip && $stable(skip_q);
  endproperty
  a_snz_blocked: assert property (p_snz_blocked)
    else $error("skip test ran with enable set");

  property p_pof_alone;
    @(posedge i_ref_clk) disable iff (i_rst)
      (ps_q == PS_RUN && pdown_only) |=> ps_q == PS_RUN ##1 !o_backup;
  endproperty
  a_pof_alone: assert property (p_pof_alone)
    else $error("power-down alone entered back-up");

  property p_pair_enters;
    @(posedge i_ref_clk) disable iff (i_rst)
      (ps_q == PS_ARMED && pdown_only) |=> ps_q == PS_BACKUP
        ##1 o_backup;
  endproperty
  a_pair_enters: assert property (p_pair_enters)
    else $error("arm then power-down missed back-up");

  property p_wake_junk;
    @(posedge i_ref_clk) disable iff (i_rst)
      wake |=> (work_q == mcb_work_t'(WORK_JUNK)) && ps_q == PS_RUN;
  endproperty
  a_wake_junk: assert property (p_wake_junk)
    else $error("work registers kept over back-up");

  property p_serial_out_pin_drive;
    @(posedge i_ref_clk) disable iff (i_rst)
      func_q[FN_SERIAL] |=> o_port_oe[P0_SERIAL_OUT_PIN]
        && o_port_pin[P0_SERIAL_OUT_PIN] == $past(i_serial_out);
  endproperty
  a_serial_out_pin_drive: assert property (p_serial_out_pin_drive)
    else $error("serial out not on port 0 bit 1");

endmodule

// ### core/mcb_pkg.sv
// Purpose: shared constants and types of the core control block
// Assumes: 32-bit classic Wishbone, byte addresses, one clock
// Notes:   work register layout is the packed struct order
package mcb_pkg;

  // ***************************************************
  // widths
  // ***************************************************
  localparam int unsigned PC_W        = 14;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SP_W        = 3;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned PORT_W      = 14;
  localparam int unsigned FN_W        = 5;
  localparam int unsigned CMD_W       = 9;
  localparam int unsigned INT_W       = 3;
  localparam int unsigned WORK_W      = 21;

  // ***************************************************
  // register byte offsets
  // ***************************************************
  localparam logic [7:0] OFS_PIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h04;
  localparam logic [7:0] OFS_KEYON    = 8'h08;
  localparam logic [7:0] OFS_CMD      = 8'h0C;
  localparam logic [7:0] OFS_STK_DATA = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_WORK     = 8'h18;
  localparam logic [7:0] OFS_INT_STAT = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK = 8'h20;
  localparam logic [7:0] OFS_PORT_OUT = 8'h24;
  localparam logic [7:0] OFS_PORT_OE  = 8'h28;
  localparam logic [7:0] OFS_PORT_IN  = 8'h2C;
  localparam logic [7:0] OFS_FUNC     = 8'h30;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int unsigned PIN_EN_BIT   = 3;
  localparam int unsigned PIN_EDGE_BIT = 2;
  localparam int unsigned EN_EXT_BIT   = 0;
  localparam int unsigned CMD_SKIP_CLR = 0;
  localparam int unsigned CMD_ARM      = 1;
  localparam int unsigned CMD_PDOWN    = 2;
  localparam int unsigned CMD_DI       = 3;
  localparam int unsigned CMD_EI       = 4;
  localparam int unsigned CMD_CALL     = 5;
  localparam int unsigned CMD_RET      = 6;
  localparam int unsigned CMD_IRQ_ENT  = 7;
  localparam int unsigned CMD_TBL_REF  = 8;
  localparam int unsigned INT_EXT      = 0;
  localparam int unsigned INT_WAKE     = 1;
  localparam int unsigned INT_OVF      = 2;
  localparam int unsigned ST_FLAG      = 0;
  localparam int unsigned ST_SKIP      = 1;
  localparam int unsigned ST_PS        = 2;
  localparam int unsigned ST_SP        = 4;
  localparam int unsigned ST_IE        = 7;
  localparam int unsigned FN_SERIAL    = 0;
  localparam int unsigned FN_TMRA_OUT  = 1;
  localparam int unsigned FN_TMRB_OUT  = 2;
  localparam int unsigned P0_SERIAL_OUT_PIN      = 1;
  localparam int unsigned P1_TMRB      = 5;
  localparam int unsigned P1_TMRA      = 6;
  localparam int unsigned PIN_INT      = 4;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [3:0]        RST_PIN_CTRL = 4'h0;
  localparam logic [3:0]        RST_IRQ_EN   = 4'h0;
  localparam logic [INT_W-1:0]  RST_INT_MASK = 3'h0;
  localparam logic [2:0]        RST_FUNC     = 3'h0;
  localparam logic [PORT_W-1:0] RST_PORT     = 14'h0000;
  localparam logic [WORK_W-1:0] WORK_JUNK    = 21'h15A5A5;

  // ***************************************************
  // types
  // ***************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mcb_wb_req_t;

  typedef struct packed {
    logic [1:0] grp;
    logic [3:0] file;
    logic [3:0] digit;
    logic [2:0] tbl_hi;
    logic [7:0] temp;
  } mcb_work_t;

  typedef enum logic [1:0] {
    PS_RUN    = 2'b00,
    PS_ARMED  = 2'b01,
    PS_BACKUP = 2'b11
  } mcb_pstate_t;

endpackage

// ### core/mcb_ret_stack.sv
// Purpose: eight-entry return stack with wrapping index
// Assumes: push and pop come from the same clock domain
// Notes:   overflow wraps and overwrites, it is only reported
`timescale 1ns/1ps
module mcb_ret_stack
  import mcb_pkg::*;
(
  // clock and reset
  input  wire logic            i_ref_clk,
  input  wire logic            i_rst,
  // requests
  input  wire logic            i_push,
  input  wire logic            i_pop,
  input  wire logic [PC_W-1:0] i_data,
  // state
  output logic      [PC_W-1:0] o_top,
  output logic      [SP_W-1:0] o_index,
  output logic                 o_ovf
);

  logic [PC_W-1:0]  entry_q [STACK_DEPTH];
  logic [CNT_W-1:0] count_q;
  logic             full;

  assign full  = (count_q == CNT_W'(STACK_DEPTH));
  assign o_top = entry_q[o_index - 3'h1];

  // entries hold no reset: contents are meaningless until pushed
  always_ff @(posedge i_ref_clk) begin
    if (i_push && !i_pop) begin
      entry_q[o_index] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_index <= '0;
      count_q <= '0;
      o_ovf   <= 1'b0;
    end else begin
      o_ovf <= i_push && !i_pop && full;
      if (i_push && !i_pop) begin
        o_index <= o_index + 3'h1;
        if (!full) begin
          count_q <= count_q + 4'h1;
        end
      end else if (i_pop && !i_push) begin
        o_index <= o_index - 3'h1;
        if (count_q != 4'h0) begin
          count_q <= count_q - 4'h1;
        end
      end
    end
  end

  property p_push_moves;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_push && !i_pop) |=> (o_index == $past(o_index) + 3'h1)
        && (o_top == $past(i_data));
  endproperty
  a_push_moves: assert property (p_push_moves)
    else $error("push did not store on top");

  property p_overflow;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_push && !i_pop && count_q == 4'h8) |=> o_ovf ##1 !o_ovf;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("ninth push not reported as overflow");

endmodule

// ### core/mcb_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static against the clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module mcb_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // pins
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// ### verif/tb_mcb_core.sv
// Purpose: self-checking bench of the core control block
// Assumes: classic Wishbone master, one 250 MHz clock
// Notes:   ack and read data are taken at the rising edge
`timescale 1ns/1ps
module tb_mcb_core
  import mcb_pkg::*;
;
  // ***************************************************
  // signals
  // ***************************************************
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  mcb_wb_req_t       req = '0;
  logic [PORT_W-1:0] pins = '0;
  logic [FN_W-1:0]   fn = '0;
  logic              wake = 1'b0;
  logic              so = 1'b0;
  logic              ack, skp, bkp, ext, irq;
  logic [31:0]       rdat, r;
  logic [PORT_W-1:0] pout, poe;
  logic [FN_W-1:0]   fin;
  int                fail_count = 0;
  int                total_checks = 0;
  logic [31:0]       rows [8][3] = '{
    '{OFS_PIN_CTRL, 32'h3, 32'h3}, '{OFS_IRQ_EN, 32'hFFFFFFFF, 32'hF},
    '{OFS_INT_MASK, 32'h7, 32'h7}, '{OFS_PORT_OUT, 32'hFFFFFFFF, 32'h3FFF},
    '{OFS_PORT_OE, 32'h1234, 32'h1234}, '{OFS_FUNC, 32'hFF, 32'h7},
    '{OFS_WORK, 32'h1ABCDE, 32'h1ABCDE}, '{8'h3C, 32'h5, 32'h0}};

  always #2 clk = ~clk;

  mcb_core u_mcb_core (.i_ref_clk(clk), .i_rst(rst), .i_wb(req),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_port_pin(pins), .o_port_pin(pout),
    .o_port_oe(poe), .i_fn_pin(fn), .i_wake_pin(wake), .o_fn_in(fin),
    .i_serial_out(so), .i_timer_out(2'h2), .o_ext_irq_req(ext),
    .o_skip(skp), .o_backup(bkp), .o_irq(irq));

  // ***************************************************
  // tasks
  // ***************************************************
  // request held until ack is seen at a rising edge; watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    req <= '0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d fails=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk({ack, bkp, irq, skp, ext}, 32'h0);
    $display("reset done");
    foreach (rows[i]) begin
      wb(1'b1, rows[i][0][7:0], rows[i][1]);
      wb(1'b0, rows[i][0][7:0], 32'h0);
      chk(r, rows[i][2]);
    end
    $display("rows done");
    wb(1'b1, OFS_IRQ_EN, 32'h0);
    wb(1'b1, OFS_PIN_CTRL, 32'h4);
    wb(1'b1, OFS_INT_STAT, 32'h7);
    @(posedge clk) fn <= 5'h10;
    repeat (5) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r[0], 1'b0);
    wb(1'b1, OFS_PIN_CTRL, 32'hC);
    repeat (5) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r[0], 1'b1);
    chk(irq, 1'b1);
    wb(1'b1, OFS_INT_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wb(1'b1, OFS_IRQ_EN, 32'h1);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_SKIP_CLR);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r[0], 1'b1);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_EI);
    repeat (2) @(posedge clk);
    chk(ext, 1'b1);
    wb(1'b1, OFS_IRQ_EN, 32'h0);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_SKIP_CLR);
    @(posedge clk) chk(skp, 1'b1);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r[1:0], 2'b10);
    $display("ext pin done");
    wb(1'b1, OFS_CMD, 32'h1 << CMD_PDOWN);
    repeat (2) @(posedge clk);
    chk(bkp, 1'b0);
    wb(1'b1, OFS_KEYON, 32'h0);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_DI);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_ARM);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_PDOWN);
    repeat (2) @(posedge clk);
    chk(bkp, 1'b1);
    @(posedge clk) wake <= 1'b1;
    repeat (5) @(posedge clk);
    chk(bkp, 1'b0);
    @(posedge clk) wake <= 1'b0;
    wb(1'b0, OFS_WORK, 32'h0);
    chk(r, {11'h000, WORK_JUNK});
    $display("power done");
    wb(1'b1, OFS_INT_STAT, 32'h7);
    wb(1'b1, OFS_STK_DATA, 32'h1234);
    for (int i = 0; i < 8; i++)
      wb(1'b1, OFS_CMD, 32'h1 << (i == 7 ? CMD_TBL_REF : CMD_CALL));
    wb(1'b0, OFS_INT_STAT, 32'h0);
    chk(r[2], 1'b0);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_IRQ_ENT);
    wb(1'b0, OFS_INT_STAT, 32'h0);
    chk(r[2], 1'b1);
    wb(1'b0, OFS_STK_DATA, 32'h0);
    chk(r, 32'h1234);
    wb(1'b1, OFS_CMD, 32'h1 << CMD_RET);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r[ST_SP +: SP_W], 3'h0);
    $display("stack done");
    wb(1'b1, OFS_PIN_CTRL, 32'h8);
    @(posedge clk) pins <= 14'h2AAA;
    fn <= 5'h0F;
    repeat (4) @(posedge clk);
    wb(1'b0, OFS_PORT_IN, 32'h0);
    chk(r, 32'h2AAA);
    chk(fin, 5'h0F);
    chk(pout, 14'h3FBD);
    chk(poe, 14'h1276);
    @(posedge clk) so <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pout, 14'h3FBF);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r[0], 1'b1);
    $display("ports done");
    conclude();
  end
endmodule
